// file: dup_edge.sv
// rise and fall detection on synchronised levels
`timescale 1ns/1ps
module dup_edge #(
   parameter int unsigned     W   = 1,
   parameter logic [W-1:0]    RST = '0
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [W-1:0]  lvl,
   output logic [W-1:0]       rise,
   output logic [W-1:0]       fall
);

   typedef struct packed {
      logic [W-1:0] prev;
   } dup_edge_st_t;

   dup_edge_st_t r;
   dup_edge_st_t next_r;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r      = r;
      next_r.prev = lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{prev: RST};
      end else begin
         r <= next_r;
      end
   end

   assign rise = lvl & ~r.prev;
   assign fall = ~lvl & r.prev;

endmodule : dup_edge

// file: dup_far_end.sv
// far-side model: serial line drivers and pad pull-ups of the multipurpose outputs
`timescale 1ns/1ps
module dup_far_end (
   input  wire logic             send_a,
   input  wire logic             bit_a,
   input  wire logic             send_b,
   input  wire logic             bit_b,
   input  wire dup_pkg::dup_op_t pad_o,
   input  wire dup_pkg::dup_op_t pad_oe,
   output logic                  line_a,
   output logic                  line_b,
   output dup_pkg::dup_op_t      pad
);
   ////////////////////////////////////////////////////////////////////////
   // lines rest at mark outside a character, high is a one
   assign line_a = send_a ? bit_a : 1'b1;
   assign line_b = send_b ? bit_b : 1'b1;
   // external pull-up gives the high level on released pins
   assign pad    = (pad_o & pad_oe) | ~pad_oe;
endmodule : dup_far_end

// file: dup_pin_mux.sv
// pin function select for the two serial channels, with apb registers
// Behaviour
// - serial lines carry high as logic one (mark) and low as zero (space).
// - transmit lines sit at mark in reset, loopback, or transmitter disabled.
// - input two gives channel b receive clock rising edges, also counter clock.
// - inputs three and five give transmit clocks a and b, falling edge.
// - input four gives channel a receive clock on its rising edge.
// - inputs zero and one optionally act as active-low clear-to-send a and b.
// - outputs zero and one carry general value or request-to-send a and b.
// - config bits 1,0 route output two: general, tx 1x, tx 16x, rx 1x of a.
// - config bits 3,2 route output three: general, counter, tx/rx 1x of b.
// - config bit 4 puts channel a receive ready or full flag on output four.
// - config bit 5 puts channel b receive ready or full flag on output five.
// - output six optionally flags channel a transmit holding empty, open drain.
// - output seven optionally flags channel b transmit holding empty, open drain.
// - reset returns all outputs and registers, line inputs and outputs idle.
// - characters go least significant bit first, bit zero first on the line.
`timescale 1ns/1ps
module dup_pin_mux (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   output logic                        irq,
   input  wire logic                   serial_in_chan_a,
   input  wire logic                   serial_in_chan_b,
   output logic                        serial_out_chan_a,
   output logic                        serial_out_chan_b,
   input  wire dup_pkg::dup_ip_t       gp_input_pins,
   output dup_pkg::dup_op_t            gp_output_o,
   output dup_pkg::dup_op_t            gp_output_oe,
   input  wire dup_pkg::dup_op_t       gp_output_in,
   input  wire dup_pkg::dup_eng_in_t   eng_in,
   output dup_pkg::dup_eng_out_t       eng_out
);

   dup_pkg::dup_st_t       r;
   dup_pkg::dup_st_t       next_r;
   logic [1:0]             rx_s;
   logic [5:0]             ip_s;
   logic [7:0]             opin_s;
   logic [5:0]             ip_rise;
   logic [5:0]             ip_fall;
   logic                   setup;
   logic                   acc;
   logic                   sts_rd;
   logic [31:0]            wm;
   logic [31:0]            rdv;
   logic                   hit;
   logic [7:0]             lvl;
   logic [7:0]             od;
   logic [3:0]             ev;
   dup_pkg::dup_op2_src_t  op2_src;
   dup_pkg::dup_op3_src_t  op3_src;

   ////////////////////////////////////////////////////////////////////////
   // pin inputs cross into pclk; reset value is the idle mark level
   dup_sync #(
      .W   (2),
      .RST (2'h3)
   ) u_rx_sync (
      .pclk_unused_guard (2'h0),
      .pclk              (pclk),
      .presetn           (presetn),
      .d                 ({serial_in_chan_b, serial_in_chan_a}),
      .q                 (rx_s)
   );

   dup_sync #(
      .W   (6),
      .RST (6'h3f)
   ) u_ip_sync (
      .pclk_unused_guard (6'h00),
      .pclk              (pclk),
      .presetn           (presetn),
      .d                 (gp_input_pins),
      .q                 (ip_s)
   );

   dup_sync #(
      .W   (8),
      .RST (8'hff)
   ) u_op_sync (
      .pclk_unused_guard (8'h00),
      .pclk              (pclk),
      .presetn           (presetn),
      .d                 (gp_output_in),
      .q                 (opin_s)
   );

   dup_edge #(
      .W   (6),
      .RST (6'h3f)
   ) u_ip_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .lvl     (ip_s),
      .rise    (ip_rise),
      .fall    (ip_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // apb decode: answer one cycle after setup, no wait beyond that
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : strb_mask

   assign setup  = psel & ~penable;
   assign acc    = psel & penable & r.pready;
   assign sts_rd = acc & ~pwrite & (paddr == dup_pkg::STS_ADDR);
   assign wm     = strb_mask(pstrb);

   // input bits read back complemented, as the port register always has
   always_comb begin
      rdv = 32'h0000_0000;
      hit = 1'b1;
      case (paddr)
         dup_pkg::CFG_ADDR:  rdv = {18'h00000, r.cfg};
         dup_pkg::GPO_ADDR:  rdv = {24'h000000, r.gpo};
         dup_pkg::PINS_ADDR: rdv = {14'h0000, rx_s, opin_s, 2'h0, ~ip_s};
         dup_pkg::STS_ADDR:  rdv = {28'h0000000, r.sts};
         dup_pkg::MSK_ADDR:  rdv = {28'h0000000, r.msk};
         default:            hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // output function select, one level and one drain flag per pin
   assign op2_src = dup_pkg::dup_op2_src_t'(r.cfg[dup_pkg::CFG_OP2_LSB +: 2]);
   assign op3_src = dup_pkg::dup_op3_src_t'(r.cfg[dup_pkg::CFG_OP3_LSB +: 2]);

   always_comb begin
      lvl = r.gpo;
      od  = 8'h00;
      if (r.cfg[dup_pkg::CFG_RTS_A]) begin
         lvl[0] = eng_in.request_to_send_n_chan_a;
      end
      if (r.cfg[dup_pkg::CFG_RTS_B]) begin
         lvl[1] = eng_in.request_to_send_n_chan_b;
      end
      case (op2_src)
         dup_pkg::OP2_TXA_BIT:  lvl[2] = eng_in.chan_a_tx_bit_clock;
         dup_pkg::OP2_TXA_OVER: lvl[2] = eng_in.chan_a_tx_oversample_clock;
         dup_pkg::OP2_RXA_BIT:  lvl[2] = eng_in.chan_a_rx_bit_clock;
         default:               lvl[2] = r.gpo[2];
      endcase
      case (op3_src)
         dup_pkg::OP3_CT: begin
            lvl[3] = eng_in.ct_out;
            od[3]  = 1'b1;
         end
         dup_pkg::OP3_TXB_BIT:  lvl[3] = eng_in.chan_b_tx_bit_clock;
         dup_pkg::OP3_RXB_BIT:  lvl[3] = eng_in.chan_b_rx_bit_clock;
         default:               lvl[3] = r.gpo[3];
      endcase
      if (r.cfg[dup_pkg::CFG_OP4_ALT]) begin
         lvl[4] = r.cfg[dup_pkg::CFG_OP4_FULL] ? eng_in.chan_a_rx_fifo_full_n
                                               : eng_in.chan_a_rx_avail_n;
         od[4]  = 1'b1;
      end
      if (r.cfg[dup_pkg::CFG_OP5_ALT]) begin
         lvl[5] = r.cfg[dup_pkg::CFG_OP5_FULL] ? eng_in.chan_b_rx_fifo_full_n
                                               : eng_in.chan_b_rx_avail_n;
         od[5]  = 1'b1;
      end
      if (r.cfg[dup_pkg::CFG_OP6_ALT]) begin
         lvl[6] = eng_in.chan_a_tx_holding_empty_n;
         od[6]  = 1'b1;
      end
      if (r.cfg[dup_pkg::CFG_OP7_ALT]) begin
         lvl[7] = eng_in.chan_b_tx_holding_empty_n;
         od[7]  = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state update
   assign ev = ip_rise[3:0] | ip_fall[3:0];

   always_comb begin
      next_r        = r;
      next_r.pready = setup;
      if (setup) begin
         next_r.prdata  = rdv;
         next_r.pslverr = ~hit;
      end
      if (acc && pwrite) begin
         case (paddr)
            dup_pkg::CFG_ADDR: next_r.cfg = (r.cfg & ~wm[13:0]) | (pwdata[13:0] & wm[13:0]);
            dup_pkg::GPO_ADDR: next_r.gpo = (r.gpo & ~wm[7:0]) | (pwdata[7:0] & wm[7:0]);
            dup_pkg::MSK_ADDR: next_r.msk = (r.msk & ~wm[3:0]) | (pwdata[3:0] & wm[3:0]);
            default: ;
         endcase
      end
      // a change landing on the clearing read is kept
      next_r.sts = (sts_rd ? 4'h0 : r.sts) | ev;
      next_r.irq = |(next_r.sts & next_r.msk);
      // line bits pass in engine order, bit zero first on the wire
      next_r.tx_a = (eng_in.tx_en_a && !eng_in.loop_a) ? eng_in.tx_data_a
                                                      : dup_pkg::LINE_MARK;
      next_r.tx_b = (eng_in.tx_en_b && !eng_in.loop_b) ? eng_in.tx_data_b
                                                      : dup_pkg::LINE_MARK;
      next_r.eng.rx_line_a = rx_s[0];
      next_r.eng.rx_line_b = rx_s[1];
      // with the function off the engine sees clear to send from the first clock after reset
      next_r.eng.clear_to_send_n_chan_a = r.cfg[dup_pkg::CFG_CTS_A] & ip_s[0];
      next_r.eng.clear_to_send_n_chan_b = r.cfg[dup_pkg::CFG_CTS_B] & ip_s[1];
      next_r.eng.ip2_rise_tick = ip_rise[2];
      next_r.eng.rx_clk_a_tick = ip_rise[4];
      next_r.eng.tx_clk_a_tick = ip_fall[3];
      next_r.eng.tx_clk_b_tick = ip_fall[5];
      // drain pins drive low only, release lets the pull-up win
      next_r.op_o  = lvl & ~od;
      next_r.op_oe = ~od | ~lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= dup_pkg::ST_RST;
      end else begin
         r <= next_r;
      end
   end

   assign prdata            = r.prdata;
   assign pready            = r.pready;
   assign pslverr           = r.pslverr;
   assign irq               = r.irq;
   assign serial_out_chan_a = r.tx_a;
   assign serial_out_chan_b = r.tx_b;
   assign gp_output_o       = r.op_o;
   assign gp_output_oe      = r.op_oe;
   assign eng_out           = r.eng;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking dup_cb @(posedge pclk);
   endclocking

   default disable iff (!presetn);

   sequence s_rose(logic b);
      !b ##1 b;
   endsequence

   sequence s_fell(logic b);
      b ##1 !b;
   endsequence

   a_tx_a_mark: assert property (
      !(eng_in.tx_en_a && !eng_in.loop_a) |=> serial_out_chan_a
   ) else $error("channel a line left mark while idle");

   a_tx_b_mark: assert property (
      !(eng_in.tx_en_b && !eng_in.loop_b) |=> serial_out_chan_b
   ) else $error("channel b line left mark while idle");

   a_tx_data_pass: assert property (
      eng_in.tx_en_a && !eng_in.loop_a |=> serial_out_chan_a == $past(eng_in.tx_data_a)
   ) else $error("channel a line level differs from engine bit");

   a_rx_clk_a: assert property (
      s_rose(ip_s[4]) |=> eng_out.rx_clk_a_tick ##1 !eng_out.rx_clk_a_tick
   ) else $error("input four rise gave no single tick");

   a_ip2_clk: assert property (
      s_rose(ip_s[2]) |=> eng_out.ip2_rise_tick
   ) else $error("input two rise gave no tick");

   a_tx_clk_a: assert property (
      s_fell(ip_s[3]) |=> eng_out.tx_clk_a_tick
   ) else $error("input three fall gave no tick");

   a_tx_clk_b: assert property (
      s_fell(ip_s[5]) |=> eng_out.tx_clk_b_tick
   ) else $error("input five fall gave no tick");

   a_cts_gate: assert property (
      r.cfg[dup_pkg::CFG_CTS_A] |=> eng_out.clear_to_send_n_chan_a == $past(ip_s[0])
   ) else $error("clear to send a not taken from input zero");

   a_rts_route: assert property (
      r.cfg[dup_pkg::CFG_RTS_A] |=> r.op_o[0] == $past(eng_in.request_to_send_n_chan_a)
   ) else $error("output zero not carrying request to send");

   a_op2_route: assert property (
      op2_src == dup_pkg::OP2_TXA_OVER
      |=> r.op_o[2] == $past(eng_in.chan_a_tx_oversample_clock) && r.op_oe[2]
   ) else $error("output two not carrying oversample clock");

   a_op3_drain: assert property (
      op3_src == dup_pkg::OP3_CT
      |=> !r.op_o[3] && r.op_oe[3] == !$past(eng_in.ct_out)
   ) else $error("output three counter drive wrong");

   a_op4_flag: assert property (
      r.cfg[dup_pkg::CFG_OP4_ALT] && !r.cfg[dup_pkg::CFG_OP4_FULL]
      |=> r.op_oe[4] == !$past(eng_in.chan_a_rx_avail_n) && !r.op_o[4]
   ) else $error("output four ready flag wrong");

   a_op5_flag: assert property (
      r.cfg[dup_pkg::CFG_OP5_ALT] && r.cfg[dup_pkg::CFG_OP5_FULL]
      |=> r.op_oe[5] == !$past(eng_in.chan_b_rx_fifo_full_n) && !r.op_o[5]
   ) else $error("output five full flag wrong");

   a_op6_flag: assert property (
      r.cfg[dup_pkg::CFG_OP6_ALT]
      |=> r.op_oe[6] == !$past(eng_in.chan_a_tx_holding_empty_n) && !r.op_o[6]
   ) else $error("output six empty flag wrong");

   a_op7_flag: assert property (
      r.cfg[dup_pkg::CFG_OP7_ALT]
      |=> r.op_oe[7] == !$past(eng_in.chan_b_tx_holding_empty_n) && !r.op_o[7]
   ) else $error("output seven empty flag wrong");

   a_gen_default: assert property (
      op2_src == dup_pkg::OP2_GEN |=> r.op_o[2] == $past(r.gpo[2]) && r.op_oe[2]
   ) else $error("output two general value not shown");

   a_sts_keep: assert property (
      r.sts[0] && !sts_rd |=> r.sts[0] ##0 (r.irq == (r.msk[0] | |(r.sts[3:1] & r.msk[3:1])))
   ) else $error("status bit lost or interrupt level wrong");

endmodule : dup_pin_mux

// file: dup_pkg.sv
// constants, carriers and state types of the dual serial pin function select
package dup_pkg;

   ////////////////////////////////////////////////////////////////////////
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] CFG_ADDR  = 8'h00;
   localparam logic [7:0] GPO_ADDR  = 8'h04;
   localparam logic [7:0] PINS_ADDR = 8'h08;
   localparam logic [7:0] STS_ADDR  = 8'h0c;
   localparam logic [7:0] MSK_ADDR  = 8'h10;

   localparam int unsigned CFG_W        = 14;
   localparam int unsigned CFG_OP2_LSB  = 0;
   localparam int unsigned CFG_OP3_LSB  = 2;
   localparam int unsigned CFG_OP4_ALT  = 4;
   localparam int unsigned CFG_OP5_ALT  = 5;
   localparam int unsigned CFG_OP6_ALT  = 6;
   localparam int unsigned CFG_OP7_ALT  = 7;
   localparam int unsigned CFG_CTS_A    = 8;
   localparam int unsigned CFG_CTS_B    = 9;
   localparam int unsigned CFG_OP4_FULL = 10;
   localparam int unsigned CFG_OP5_FULL = 11;
   localparam int unsigned CFG_RTS_A    = 12;
   localparam int unsigned CFG_RTS_B    = 13;

   localparam logic        LINE_MARK = 1'b1;
   localparam logic [13:0] CFG_RST   = 14'h0000;
   localparam logic [7:0]  GPO_RST   = 8'hff;
   localparam logic [3:0]  MSK_RST   = 4'h0;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      OP2_GEN = 2'h0, OP2_TXA_BIT = 2'h1, OP2_TXA_OVER = 2'h2, OP2_RXA_BIT = 2'h3
   } dup_op2_src_t;

   typedef enum logic [1:0] {
      OP3_GEN = 2'h0, OP3_CT = 2'h1, OP3_TXB_BIT = 2'h2, OP3_RXB_BIT = 2'h3
   } dup_op3_src_t;

   typedef struct packed {
      logic gp_input_five;
      logic gp_input_four;
      logic gp_input_three;
      logic gp_input_two;
      logic gp_input_one;
      logic gp_input_zero;
   } dup_ip_t;

   typedef struct packed {
      logic gp_output_seven;
      logic gp_output_six;
      logic gp_output_five;
      logic gp_output_four;
      logic gp_output_three;
      logic gp_output_two;
      logic gp_output_one;
      logic gp_output_zero;
   } dup_op_t;

   typedef struct packed {
      logic tx_data_a;
      logic tx_data_b;
      logic tx_en_a;
      logic tx_en_b;
      logic loop_a;
      logic loop_b;
      logic request_to_send_n_chan_a;
      logic request_to_send_n_chan_b;
      logic chan_a_tx_bit_clock;
      logic chan_a_tx_oversample_clock;
      logic chan_a_rx_bit_clock;
      logic chan_b_tx_bit_clock;
      logic chan_b_rx_bit_clock;
      logic ct_out;
      logic chan_a_rx_avail_n;
      logic chan_a_rx_fifo_full_n;
      logic chan_b_rx_avail_n;
      logic chan_b_rx_fifo_full_n;
      logic chan_a_tx_holding_empty_n;
      logic chan_b_tx_holding_empty_n;
   } dup_eng_in_t;

   typedef struct packed {
      logic rx_line_a;
      logic rx_line_b;
      logic clear_to_send_n_chan_a;
      logic clear_to_send_n_chan_b;
      logic rx_clk_a_tick;
      logic ip2_rise_tick;
      logic tx_clk_a_tick;
      logic tx_clk_b_tick;
   } dup_eng_out_t;

   localparam dup_eng_out_t ENG_OUT_RST = 8'hf0;

   typedef struct packed {
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
      logic [13:0]  cfg;
      logic [7:0]   gpo;
      logic [3:0]   sts;
      logic [3:0]   msk;
      logic         irq;
      logic         tx_a;
      logic         tx_b;
      logic [7:0]   op_o;
      logic [7:0]   op_oe;
      dup_eng_out_t eng;
   } dup_st_t;

   localparam dup_st_t ST_RST = '{
      prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
      cfg: CFG_RST, gpo: GPO_RST, sts: 4'h0, msk: MSK_RST, irq: 1'b0,
      tx_a: LINE_MARK, tx_b: LINE_MARK, op_o: 8'hff, op_oe: 8'hff,
      eng: ENG_OUT_RST
   };

endpackage : dup_pkg

// file: dup_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module dup_sync #(
   parameter int unsigned     W   = 1,
   parameter logic [W-1:0]    RST = '0
) (
   input  wire logic [W-1:0]  pclk_unused_guard,
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [W-1:0]  d,
   output logic [W-1:0]       q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dup_sync_st_t;

   dup_sync_st_t r;
   dup_sync_st_t next_r;

   ////////////////////////////////////////////////////////////////////////
   // first stage feeds only the second stage
   always_comb begin
      next_r    = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{s1: RST, s2: RST};
      end else begin
         r <= next_r;
      end
   end

   assign q = r.s2;

endmodule : dup_sync

// file: dup_tb.sv
// self-checking testbench of the pin function select
`timescale 1ns/1ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic sin_a, sin_b, sout_a, sout_b, snd_a, bit_a;
   dup_pkg::dup_ip_t gpi;
   dup_pkg::dup_op_t op_o, op_oe, pad;
   dup_pkg::dup_eng_in_t eng;
   dup_pkg::dup_eng_out_t eng_out;
   int err_total, cmp_count, cyc_n;

   dup_pin_mux i_dup_pin_mux (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .serial_in_chan_a(sin_a), .serial_in_chan_b(sin_b), .serial_out_chan_a(sout_a),
      .serial_out_chan_b(sout_b), .gp_input_pins(gpi), .gp_output_o(op_o), .gp_output_oe(op_oe),
      .gp_output_in(pad), .eng_in(eng), .eng_out(eng_out));
   dup_far_end i_dup_far_end (.send_a(snd_a), .bit_a(bit_a), .send_b(1'b0), .bit_b(1'b0), .pad_o(op_o),
      .pad_oe(op_oe), .line_a(sin_a), .line_b(sin_b), .pad(pad));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   // ceiling far above the few hundred cycles the tests need
   always @(posedge pclk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         err_total++;
         end_sim();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   ////////////////////////////////////////////////////////////////////////
   // the trailing idle cycle keeps two transfers from touching psel in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(n, x, r);
   endtask : rd

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] r;
      logic e;
      chk("tx lines", 2'b11, {sout_a, sout_b});
      chk("op o", 8'hff, op_o);
      chk("op oe", 8'hff, op_oe);
      chk("eng out", 8'hf0, eng_out);
      rd(dup_pkg::CFG_ADDR, 32'h0, "cfg");
      rd(dup_pkg::GPO_ADDR, 32'hff, "gpo");
      rd(dup_pkg::MSK_ADDR, 32'h0, "msk");
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk("unmapped err", 1'b1, e);
      chk("unmapped data", 32'h0, r);
      wr(dup_pkg::GPO_ADDR, 32'h5a);
      cyc(6);
      chk("gen out", 8'h5a, op_o);
      rd(dup_pkg::PINS_ADDR, 32'h0003_5a00, "pins");
      $display("test reset done");
   endtask : t_reset

   task automatic t_op23;
      int s;
      wr(dup_pkg::GPO_ADDR, 32'hff);
      for (s = 0; s < 4; s++) begin
         eng.chan_a_tx_bit_clock <= s > 0 && s != 1;
         eng.chan_a_tx_oversample_clock <= s > 0 && s != 2;
         eng.chan_a_rx_bit_clock <= s > 0 && s != 3;
         eng.ct_out <= s > 0 && s != 1;
         eng.chan_b_tx_bit_clock <= s > 0 && s != 2;
         eng.chan_b_rx_bit_clock <= s > 0 && s != 3;
         wr(dup_pkg::CFG_ADDR, 32'(s * 5));
         cyc(3);
         chk("op2", s == 0, op_o.gp_output_two);
         chk("op3", s == 0, op_o.gp_output_three);
         chk("op3 oe", 1'b1, op_oe.gp_output_three);
      end
      eng.ct_out <= 1'b1;
      wr(dup_pkg::CFG_ADDR, 32'h4);
      cyc(3);
      chk("ct released", 1'b0, op_oe.gp_output_three);
      $display("test op2 op3 done");
   endtask : t_op23

   task automatic t_flags;
      eng.chan_a_rx_avail_n <= 1'b0;
      eng.chan_b_rx_avail_n <= 1'b0;
      eng.chan_a_tx_holding_empty_n <= 1'b0;
      eng.request_to_send_n_chan_a <= 1'b0;
      wr(dup_pkg::CFG_ADDR, 32'h30f0);
      cyc(3);
      chk("flag oe", 4'b0111, op_oe[7:4]);
      chk("flag o", 3'b000, op_o[6:4]);
      chk("rts", 2'b10, op_o[1:0]);
      eng.chan_b_rx_fifo_full_n <= 1'b0;
      wr(dup_pkg::CFG_ADDR, 32'h0cf0);
      cyc(3);
      chk("full oe", 4'b0110, op_oe[7:4]);
      chk("rts off", 2'b11, op_o[1:0]);
      gpi[1] <= 1'b0;
      wr(dup_pkg::CFG_ADDR, 32'h0300);
      cyc(6);
      chk("cts", 2'b10, {eng_out.clear_to_send_n_chan_a, eng_out.clear_to_send_n_chan_b});
      wr(dup_pkg::CFG_ADDR, 32'h0);
      cyc(4);
      chk("cts off", 2'b00, {eng_out.clear_to_send_n_chan_a, eng_out.clear_to_send_n_chan_b});
      gpi[1] <= 1'b1;
      $display("test flags done");
   endtask : t_flags

   // no pulse after driving the opposite level (an edge only for the rising-edge pins, which start high), at least one pulse on the documented edge
   task automatic tick(input int p, input logic lv, input int ob);
      logic seen;
      seen = 1'b0;
      gpi[p] <= ~lv;
      repeat (8) begin
         @(posedge pclk);
         seen |= eng_out[ob];
      end
      chk("no tick", 1'b0, seen);
      seen = 1'b0;
      gpi[p] <= lv;
      repeat (8) begin
         @(posedge pclk);
         seen |= eng_out[ob];
      end
      chk("tick", 1'b1, seen);
   endtask : tick

   task automatic t_irq;
      logic [31:0] r;
      logic e;
      apb(1'b0, dup_pkg::STS_ADDR, 32'h0, r, e);
      wr(dup_pkg::MSK_ADDR, 32'h1);
      gpi[0] <= 1'b0;
      cyc(10);
      chk("irq set", 1'b1, irq);
      rd(dup_pkg::STS_ADDR, 32'h1, "sts");
      cyc(2);
      chk("irq clr", 1'b0, irq);
      wr(dup_pkg::MSK_ADDR, 32'h0);
      gpi[0] <= 1'b1;
      cyc(10);
      chk("irq masked", 1'b0, irq);
      rd(dup_pkg::STS_ADDR, 32'h1, "sts masked");
      $display("test irq done");
   endtask : t_irq

   task automatic t_line;
      int i;
      logic [7:0] ch;
      ch = 8'h35;
      snd_a <= 1'b1;
      bit_a <= 1'b0;
      cyc(5);
      chk("rx line", 1'b0, eng_out.rx_line_a);
      snd_a <= 1'b0;
      cyc(5);
      chk("rx idle", 1'b1, eng_out.rx_line_a);
      eng.tx_en_a <= 1'b1;
      eng.loop_a <= 1'b0;
      for (i = 0; i < 8; i++) begin
         eng.tx_data_a <= ch[i];
         cyc(2);
         chk("tx bit", ch[i], sout_a);
      end
      eng.tx_data_a <= 1'b0;
      eng.loop_a <= 1'b1;
      cyc(2);
      chk("tx loop", 1'b1, sout_a);
      eng.loop_a <= 1'b0;
      eng.tx_en_a <= 1'b0;
      cyc(2);
      chk("tx off", 1'b1, sout_a);
      eng.tx_data_b <= 1'b0;
      eng.tx_en_b <= 1'b1;
      eng.loop_b <= 1'b0;
      cyc(2);
      chk("tx b bit", 1'b0, sout_b);
      eng.loop_b <= 1'b1;
      cyc(2);
      chk("tx b loop", 1'b1, sout_b);
      eng.tx_en_a <= 1'b1;
      wr(dup_pkg::CFG_ADDR, 32'h5);
      cyc(1);
      presetn <= 1'b0;
      #1;
      chk("tx in reset", 1'b1, sout_a);
      cyc(2);
      presetn <= 1'b1;
      cyc(1);
      rd(dup_pkg::CFG_ADDR, 32'h0, "cfg after reset");
      $display("test line done");
   endtask : t_line

   ////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, snd_a, bit_a} = '0;
      paddr = '0;
      pwdata = '0;
      gpi = '1;
      eng = '1;
      {err_total, cmp_count, cyc_n} = '0;
      cyc(2);
      presetn <= 1'b1;
      cyc(1);
      t_reset();
      t_op23();
      t_flags();
      tick(2, 1'b1, 2);
      tick(4, 1'b1, 3);
      tick(3, 1'b0, 1);
      tick(5, 1'b0, 0);
      $display("test ticks done");
      t_irq();
      t_line();
      end_sim();
   end
endmodule : tb
